// ---- bench/pic_host.sv ----
`timescale 1ns/10ps
module pic_host
  import pic_pkg::*;
(
  // clock
  input  wire logic i_clk_sys,
  // serial pins, data open drain
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull
);
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // data moves two clocks into the low phase, clear of both clock edges
  task automatic bit_io(input logic b, output logic s);
    o_scl <= 1'b0;
    hold(2);
    o_sda_pull <= ~b;
    hold(5);
    o_scl <= 1'b1;
    hold(5);
    s = i_sda;
    hold(1);
  endtask
  // lvl 0 gives a start, lvl 1 a stop
  task automatic cond(input logic lvl);
    logic s;
    bit_io(~lvl, s);
    o_sda_pull <= ~lvl;
    hold(6);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic m_ack, output logic [7:0] q,
                         inout int acks);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m_ack, s);
    acks += int'(!s);
  endtask
  // start and address, then pointer as high byte then low byte
  task automatic head(input logic [1:0] pins, input logic [15:0] ptr, output int acks);
    logic [7:0] q;
    acks = 0;
    cond(1'b0);
    byte_io({DEV_ADDR_FIXED, pins, 1'b0}, 1'b1, q, acks);
    byte_io(ptr[15:8], 1'b1, q, acks);
    byte_io(ptr[7:0], 1'b1, q, acks);
  endtask
  task automatic wr(input logic [1:0] pins, input logic [15:0] ptr, input logic [15:0] dat,
                    output int acks);
    logic [7:0] q;
    head(pins, ptr, acks);
    byte_io(dat[15:8], 1'b1, q, acks);
    byte_io(dat[7:0], 1'b1, q, acks);
    cond(1'b1);
  endtask
  // the host acks the high byte and refuses the low one to end the read
  task automatic rd(input logic [1:0] pins, input logic [15:0] ptr, output logic [15:0] dat,
                    output int acks);
    logic [7:0] q;
    head(pins, ptr, acks);
    cond(1'b0);
    byte_io({DEV_ADDR_FIXED, pins, 1'b1}, 1'b1, q, acks);
    byte_io(8'hFF, 1'b0, dat[15:8], acks);
    byte_io(8'hFF, 1'b1, dat[7:0], acks);
    cond(1'b1);
  endtask
endmodule // pic_host

// ---- bench/pic_regs_asserts.sv ----
`timescale 1ns/10ps
module pic_regs_asserts (
  // clock and reset
  input logic        i_clk_sys,
  input logic        i_nrst,
  // serial port
  input logic        i_scl,
  input logic        o_sda_oe,
  // controls
  input logic [13:0] o_reference_divider,
  input logic [14:0] o_reference_ratio,
  input logic [9:0]  o_feedback_divider_first,
  input logic [10:0] o_feedback_first_ratio,
  input logic [7:0]  o_feedback_divider_second,
  input logic [8:0]  o_feedback_second_ratio,
  input logic [2:0]  o_prescaler_first_ratio,
  input logic        o_prescaler_first_reserved,
  input logic [2:0]  o_prescaler_second_ratio,
  input logic        o_prescaler_second_reserved,
  input logic        o_input_mux_manual,
  input logic        o_ref_use_secondary,
  input logic [4:0]  o_primary_input_ratio,
  input logic [1:0]  o_primary_buffer_type
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence scl_high3;
    i_scl [*3];
  endsequence
  // commit lands at the fall that opens the low byte's acknowledge
  sequence ack_soon;
    ##[0:3] o_sda_oe;
  endsequence
  ref_ratio_a: assert property (o_reference_ratio == o_reference_divider + 15'h0001)
    else $error("reference ratio wrong");
  fb_first_a: assert property (o_feedback_first_ratio == o_feedback_divider_first + 11'h001)
    else $error("first feedback ratio wrong");
  fb_second_a: assert property (o_feedback_second_ratio == o_feedback_divider_second + 9'h001)
    else $error("second feedback ratio wrong");
  ps_second_a: assert property (o_prescaler_second_reserved ? o_prescaler_second_ratio == 3'h0
    : o_prescaler_second_ratio inside {[3'h4:3'h6]}) else $error("second prescaler wrong");
  ps_first_a: assert property (o_prescaler_first_reserved ? o_prescaler_first_ratio == 3'h0
    : o_prescaler_first_ratio inside {[3'h4:3'h6]}) else $error("first prescaler wrong");
  sec_manual_a: assert property (o_ref_use_secondary |-> o_input_mux_manual)
    else $error("secondary chosen outside manual mode");
  pri_div_a: assert property (o_primary_input_ratio inside {[5'h01:5'h10]})
    else $error("primary ratio out of range");
  pri_buf_a: assert property (o_primary_buffer_type != 2'h3)
    else $error("primary buffer code 11 shown");
  ack_hold_a: assert property (scl_high3 |-> $stable(o_sda_oe))
    else $error("data line moved with clock high");
  commit_ack_a: assert property ($changed(o_reference_divider) |-> ack_soon)
    else $error("register changed without acknowledge");
endmodule // pic_regs_asserts

bind pic_regs pic_regs_asserts u_chk (.i_clk_sys, .i_nrst, .i_scl, .o_sda_oe,
  .o_reference_divider, .o_reference_ratio, .o_feedback_divider_first,
  .o_feedback_first_ratio, .o_feedback_divider_second, .o_feedback_second_ratio,
  .o_prescaler_first_ratio, .o_prescaler_first_reserved, .o_prescaler_second_ratio,
  .o_prescaler_second_reserved, .o_input_mux_manual, .o_ref_use_secondary,
  .o_primary_input_ratio, .o_primary_buffer_type);

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; $display(\
"unexpected at %0t got %h expected %h", $time, (g), (e)); end end
module testbench
  import pic_pkg::*;
;
  logic        i_clk_sys, i_nrst, i_scl, i_sda, sda_pull, i_ref_sel_pin;
  logic        i_pll_lock, i_loss_ref, i_refclk_status, o_sda_out, o_sda_oe;
  logic        o_status0, o_status1, o_core_reset_n, o_divider_sync, o_vco_cal_enable;
  logic        o_prescaler_first_reserved, o_prescaler_second_reserved, o_mux_delay_enable;
  logic        o_mux_reshape_enable, o_input_mux_manual, o_ref_use_secondary;
  logic        o_secondary_input_enable, o_primary_input_enable;
  logic        o_secondary_supply_select, o_primary_supply_select;
  logic [1:0]  i_addr_pins, o_secondary_buffer_type, o_primary_buffer_type;
  logic [2:0]  o_prescaler_first_ratio, o_prescaler_second_ratio;
  logic [4:0]  o_primary_input_ratio;
  logic [7:0]  o_feedback_divider_second;
  logic [8:0]  o_feedback_second_ratio;
  logic [9:0]  o_feedback_divider_first;
  logic [10:0] o_feedback_first_ratio;
  logic [13:0] o_reference_divider;
  logic [14:0] o_reference_ratio;
  logic [15:0] q;
  int          err_count, total_checks, n;

  // pull-up wins unless either side pulls low
  assign i_sda = (o_sda_oe ? o_sda_out : 1'b1) & ~sda_pull;
  always #5 i_clk_sys = ~i_clk_sys;

  pic_regs u_dut (.i_clk_sys, .i_nrst, .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .i_addr_pins,
    .i_pll_lock, .i_loss_ref, .i_refclk_status, .i_ref_sel_pin, .o_status0, .o_status1,
    .o_reference_divider, .o_reference_ratio, .o_feedback_divider_first,
    .o_feedback_first_ratio, .o_feedback_divider_second, .o_feedback_second_ratio,
    .o_core_reset_n, .o_divider_sync, .o_vco_cal_enable, .o_prescaler_first_ratio,
    .o_prescaler_first_reserved, .o_prescaler_second_ratio, .o_prescaler_second_reserved,
    .o_mux_delay_enable, .o_mux_reshape_enable, .o_input_mux_manual, .o_ref_use_secondary,
    .o_primary_input_ratio, .o_secondary_buffer_type, .o_secondary_input_enable,
    .o_primary_buffer_type, .o_primary_input_enable, .o_secondary_supply_select,
    .o_primary_supply_select);
  pic_host u_host (.i_clk_sys, .i_sda, .o_scl(i_scl), .o_sda_pull(sda_pull));

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  function automatic logic [2:0] ps_ratio(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : 3'h4 + {1'b0, c};
  endfunction
  task automatic wr_rd(input logic [15:0] ptr, input logic [15:0] dat);
    u_host.wr(i_addr_pins, ptr, dat, n);
    `CHK(n, 5)
    u_host.rd(i_addr_pins, ptr, q, n);
    `CHK(n, 5)
    `CHK(q, dat)
  endtask
  task automatic t_reset();
    logic [15:0] rv [4] = '{RST_REF_DIV_FB_HIGH, RST_FEEDBACK_DIVIDERS,
                            RST_STATUS_RESET_PRESCALE, RST_INPUT_SELECT_CONFIG};
    for (int k = 1; k <= 4; k++) begin
      u_host.rd(i_addr_pins, k[15:0], q, n);
      `CHK(q, rv[k-1])
    end
    `CHK(o_core_reset_n, 1'b1)
    `CHK(o_divider_sync, 1'b0)
    `CHK(o_reference_ratio, 15'h0001)
    $display("test reset done");
  endtask
  task automatic t_pll();
    wr_rd(REG_REF_DIV_FB_HIGH, 16'hFFFD);
    wr_rd(REG_FEEDBACK_DIVIDERS, 16'h8007);
    `CHK(o_reference_ratio, 15'h4000)
    `CHK(o_feedback_first_ratio, 11'h181)
    `CHK(o_feedback_second_ratio, 9'h008)
    `CHK(o_reference_divider, 14'h3FFF)
    `CHK({o_feedback_divider_first, o_feedback_divider_second}, {10'h180, 8'h07})
    u_host.rd(i_addr_pins, REG_REF_DIV_FB_HIGH, q, n);
    `CHK(q, 16'hFFFD)
    $display("test pll done");
  endtask
  task automatic t_prescale();
    for (int k = 0; k < 4; k++) begin
      // reserved top bits written as zero
      wr_rd(REG_STATUS_RESET_PRESCALE, {11'h003, k[0], k[1:0], ~k[1:0]});
      `CHK(o_prescaler_second_ratio, ps_ratio(k[1:0]))
      `CHK(o_prescaler_second_reserved, k == 3)
      `CHK(o_prescaler_first_ratio, ps_ratio(~k[1:0]))
      `CHK(o_prescaler_first_reserved, k == 0)
      `CHK(o_vco_cal_enable, k[0])
    end
    wr_rd(REG_STATUS_RESET_PRESCALE, 16'h0000);
    `CHK(o_core_reset_n, 1'b0)
    `CHK(o_divider_sync, 1'b1)
    u_host.rd(i_addr_pins, REG_FEEDBACK_DIVIDERS, q, n);
    `CHK(q, 16'h8007)
    $display("test prescale done");
  endtask
  task automatic t_status();
    logic [15:0] cfg [2] = '{16'h0760, 16'h18E0};
    for (int c = 0; c < 2; c++) begin
      wr_rd(REG_STATUS_RESET_PRESCALE, cfg[c]);
      for (int k = 0; k < 8; k++) begin
        {i_refclk_status, i_loss_ref, i_pll_lock} <= k[2:0];
        repeat (5) @(posedge i_clk_sys);
        `CHK(o_status1, |(k[2:0] & cfg[c][12:10]))
        `CHK(o_status0, |(k[2:0] & cfg[c][9:7]))
      end
    end
    $display("test status done");
  endtask
  task automatic t_input();
    for (int k = 0; k < 4; k++) begin
      i_ref_sel_pin <= k[0];
      wr_rd(REG_INPUT_SELECT_CONFIG, {k[1:0], 2'h3, k[1:0], k[1:0], k[1:0], 1'b1,
                                      k[1:0], 1'b1, k[1:0]});
      `CHK({o_mux_reshape_enable, o_mux_delay_enable}, k[1:0])
      `CHK(o_input_mux_manual, 1'b1)
      `CHK(o_ref_use_secondary, k[0])
      `CHK(o_primary_input_ratio, {1'b0, k[1:0], k[1:0]} + 5'h01)
      `CHK(o_secondary_buffer_type, k[1:0])
      `CHK(o_primary_buffer_type, (k == 3) ? 2'h2 : k[1:0])
      `CHK({o_secondary_supply_select, o_primary_supply_select}, k[1:0])
      `CHK({o_secondary_input_enable, o_primary_input_enable}, 2'h3)
    end
    // automatic mode, both buffers on, supply bits rewritten
    wr_rd(REG_INPUT_SELECT_CONFIG, 16'h1027);
    `CHK(o_input_mux_manual, 1'b0)
    `CHK(o_ref_use_secondary, 1'b0)
    $display("test input done");
  endtask
  task automatic t_refuse();
    u_host.wr(~i_addr_pins, REG_REF_DIV_FB_HIGH, 16'h0000, n);
    `CHK(n, 0)
    u_host.wr(i_addr_pins, 16'h0005, 16'hFFFF, n);
    `CHK(n, 5)
    u_host.rd(i_addr_pins, 16'h0005, q, n);
    `CHK(q, 16'h0000)
    u_host.rd(i_addr_pins, REG_REF_DIV_FB_HIGH, q, n);
    `CHK(q, 16'hFFFD)
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    u_host.rd(i_addr_pins, REG_REF_DIV_FB_HIGH, q, n);
    `CHK(q, RST_REF_DIV_FB_HIGH)
    $display("test refuse done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // run
  // ----------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    i_nrst = 1'b0;
    i_addr_pins = 2'h2;
    i_ref_sel_pin = 1'b0;
    {i_pll_lock, i_loss_ref, i_refclk_status} = 3'h0;
    repeat (10) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    t_reset();
    t_pll();
    t_prescale();
    t_status();
    t_input();
    t_refuse();
    stop_test();
  end
  // a hung transfer ends the run as a mismatch
  initial begin
    repeat (100000) @(posedge i_clk_sys);
    err_count++;
    stop_test();
  end
endmodule // testbench

// ---- logic/pic_pkg.sv ----
// What this block does
// - reference divider 14 bits, ratio value plus one
// - first feedback divider split, ratio plus one
// - second feedback divider 8 bits, plus one
// - three enables route indications to status 1
// - three enables route indications to status 0
// - soft reset bit holds core, keeps registers
// - cleared sync bit forces output divider sync
// - calibration enable bit drives oscillator calibration
// - second prescaler 4/5/6, reserved code flagged
// - first prescaler same coding, feeds feedback
// - shaping field enables delay and reshape
// - mode bit picks automatic or manual selection
// - buffer enables; automatic mode needs both set
// - manual choice secondary only with pin high
// - primary input divider code plus one
// - secondary buffer type four codes
// - primary buffer type, codes 10/11 same
// - supply select bits, 0 is 1.8 V
// - registers move as two bytes, high first
package pic_pkg;

  // ----------------------------------------
  // register indices on the serial port
  // ----------------------------------------
  localparam logic [15:0] REG_REF_DIV_FB_HIGH       = 16'h0001;
  localparam logic [15:0] REG_FEEDBACK_DIVIDERS     = 16'h0002;
  localparam logic [15:0] REG_STATUS_RESET_PRESCALE = 16'h0003;
  localparam logic [15:0] REG_INPUT_SELECT_CONFIG   = 16'h0004;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] RST_REF_DIV_FB_HIGH       = 16'h0000;
  localparam logic [15:0] RST_FEEDBACK_DIVIDERS     = 16'h0000;
  localparam logic [15:0] RST_STATUS_RESET_PRESCALE = 16'h0060;
  localparam logic [15:0] RST_INPUT_SELECT_CONFIG   = 16'h0024;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int REFDIV_LSB    = 2;
  localparam int REFDIV_MSB    = 15;
  localparam int FB1_HI_MSB    = 1;
  localparam int FB1_LO_LSB    = 8;
  localparam int ST1_REFCLK    = 12;
  localparam int ST1_LOSS      = 11;
  localparam int ST1_LOCK      = 10;
  localparam int ST0_REFCLK    = 9;
  localparam int ST0_LOSS      = 8;
  localparam int ST0_LOCK      = 7;
  localparam int SOFT_RST_BIT  = 6;
  localparam int SYNC_BIT      = 5;
  localparam int CAL_BIT       = 4;
  localparam int PS2_LSB       = 2;
  localparam int PS1_LSB       = 0;
  localparam int SHAPE_LSB     = 14;
  localparam int MODE_BIT      = 13;
  localparam int CHOICE_BIT    = 12;
  localparam int PRIDIV_LSB    = 8;
  localparam int SECBUF_LSB    = 6;
  localparam int SEC_EN_BIT    = 5;
  localparam int PRIBUF_LSB    = 3;
  localparam int PRI_EN_BIT    = 2;
  localparam int SEC_SUP_BIT   = 1;
  localparam int PRI_SUP_BIT   = 0;

  // ----------------------------------------
  // serial port constants
  // ----------------------------------------
  localparam logic [4:0] DEV_ADDR_FIXED = 5'h15;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [2:0] BYTES_PER_WR   = 3'h4;

  // ----------------------------------------
  // codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PIC_BUF_CML   = 2'h0,
    PIC_BUF_LVDS  = 2'h1,
    PIC_BUF_CMOS  = 2'h2,
    PIC_BUF_XTAL  = 2'h3
  } pic_buf_t;

  typedef enum logic [2:0] {
    PIC_IDLE     = 3'h0,
    PIC_ADDR     = 3'h1,
    PIC_ADDR_ACK = 3'h3,
    PIC_RX       = 3'h2,
    PIC_RX_ACK   = 3'h6,
    PIC_TX       = 3'h7,
    PIC_TX_ACK   = 3'h5
  } pic_fsm_t;

  typedef struct packed {
    pic_fsm_t    fsm;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic        rw;
    logic [2:0]  bytecnt;
    logic [15:0] ptr;
    logic [7:0]  wdat_hi;
    logic [7:0]  tx_lo;
    logic        tx_sel;
    logic        sda_oe;
    logic        scl_q;
    logic        sda_q;
    logic [15:0] reg1;
    logic [15:0] reg2;
    logic [15:0] reg3;
    logic [15:0] reg4;
  } pic_state_t;

endpackage

// ---- logic/pic_prescale.sv ----
`timescale 1ns/10ps
module pic_prescale
  import pic_pkg::*;
(
  // selection
  input  wire logic [1:0] i_code,
  // decoded
  output logic      [2:0] o_ratio,
  output logic            o_reserved
);
  // reserved code gives ratio zero so nothing downstream runs on it
  always_comb begin
    o_reserved = 1'b0;
    case (i_code)
      2'h0:    o_ratio = 3'h4;
      2'h1:    o_ratio = 3'h5;
      2'h2:    o_ratio = 3'h6;
      default: begin
        o_ratio    = 3'h0;
        o_reserved = 1'b1;
      end
    endcase
  end
endmodule // pic_prescale

// ---- logic/pic_regs.sv ----
`timescale 1ns/10ps
module pic_regs
  import pic_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // serial configuration port, open drain data
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  input  wire logic [1:0]  i_addr_pins,
  // analog side indications and pins
  input  wire logic        i_pll_lock,
  input  wire logic        i_loss_ref,
  input  wire logic        i_refclk_status,
  input  wire logic        i_ref_sel_pin,
  // status pins
  output logic             o_status0,
  output logic             o_status1,
  // pll controls
  output logic [13:0]      o_reference_divider,
  output logic [14:0]      o_reference_ratio,
  output logic [9:0]       o_feedback_divider_first,
  output logic [10:0]      o_feedback_first_ratio,
  output logic [7:0]       o_feedback_divider_second,
  output logic [8:0]       o_feedback_second_ratio,
  output logic             o_core_reset_n,
  output logic             o_divider_sync,
  output logic             o_vco_cal_enable,
  output logic [2:0]       o_prescaler_first_ratio,
  output logic             o_prescaler_first_reserved,
  output logic [2:0]       o_prescaler_second_ratio,
  output logic             o_prescaler_second_reserved,
  // input section controls
  output logic             o_mux_delay_enable,
  output logic             o_mux_reshape_enable,
  output logic             o_input_mux_manual,
  output logic             o_ref_use_secondary,
  output logic [4:0]       o_primary_input_ratio,
  output logic [1:0]       o_secondary_buffer_type,
  output logic             o_secondary_input_enable,
  output logic [1:0]       o_primary_buffer_type,
  output logic             o_primary_input_enable,
  output logic             o_secondary_supply_select,
  output logic             o_primary_supply_select
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [7:0] pins_sync;
  logic       scl_s;
  logic       sda_s;
  logic [1:0] addr_s;
  logic       lock_s;
  logic       loss_s;
  logic       refclk_s;
  logic       refsel_s;

  pic_sync #(
    .W (8)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   ({i_scl, i_sda, i_addr_pins, i_pll_lock, i_loss_ref,
                 i_refclk_status, i_ref_sel_pin}),
    .o_sync    (pins_sync)
  );

  assign scl_s    = pins_sync[7];
  assign sda_s    = pins_sync[6];
  assign addr_s   = pins_sync[5:4];
  assign lock_s   = pins_sync[3];
  assign loss_s   = pins_sync[2];
  assign refclk_s = pins_sync[1];
  assign refsel_s = pins_sync[0];

  // ----------------------------------------
  // state
  // ----------------------------------------
  pic_state_t st_ff;
  pic_state_t nxt_st;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [15:0] rd_word;

  assign scl_rise   = scl_s & ~st_ff.scl_q;
  assign scl_fall   = ~scl_s & st_ff.scl_q;
  assign start_cond = scl_s & st_ff.scl_q & st_ff.sda_q & ~sda_s;
  assign stop_cond  = scl_s & st_ff.scl_q & ~st_ff.sda_q & sda_s;

  always_comb begin
    case (st_ff.ptr)
      REG_REF_DIV_FB_HIGH:       rd_word = st_ff.reg1;
      REG_FEEDBACK_DIVIDERS:     rd_word = st_ff.reg2;
      REG_STATUS_RESET_PRESCALE: rd_word = st_ff.reg3;
      REG_INPUT_SELECT_CONFIG:   rd_word = st_ff.reg4;
      default:                   rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // serial port engine
  // ----------------------------------------
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.scl_q = scl_s;
    nxt_st.sda_q = sda_s;
    if (start_cond) begin
      // repeated start keeps the register pointer for reads
      nxt_st.fsm     = PIC_ADDR;
      nxt_st.bitcnt  = 4'h0;
      nxt_st.bytecnt = 3'h0;
      nxt_st.sda_oe  = 1'b0;
    end else if (stop_cond) begin
      nxt_st.fsm    = PIC_IDLE;
      nxt_st.sda_oe = 1'b0;
    end else begin
      case (st_ff.fsm)
        PIC_IDLE: begin
          nxt_st.sda_oe = 1'b0;
        end
        PIC_ADDR: begin
          if (scl_rise) begin
            nxt_st.shreg  = {st_ff.shreg[6:0], sda_s};
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          end else if (scl_fall && st_ff.bitcnt == BITS_PER_BYTE) begin
            if (st_ff.shreg[7:1] == {DEV_ADDR_FIXED, addr_s}) begin
              nxt_st.sda_oe = 1'b1;
              nxt_st.rw     = st_ff.shreg[0];
              nxt_st.fsm    = PIC_ADDR_ACK;
            end else begin
              nxt_st.fsm = PIC_IDLE;
            end
          end
        end
        PIC_ADDR_ACK: begin
          if (scl_fall) begin
            nxt_st.bitcnt = 4'h0;
            if (st_ff.rw) begin
              nxt_st.shreg  = rd_word[15:8];
              nxt_st.tx_lo  = rd_word[7:0];
              nxt_st.tx_sel = 1'b0;
              nxt_st.sda_oe = ~rd_word[15];
              nxt_st.fsm    = PIC_TX;
            end else begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.fsm    = PIC_RX;
            end
          end
        end
        PIC_RX: begin
          if (scl_rise) begin
            nxt_st.shreg  = {st_ff.shreg[6:0], sda_s};
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          end else if (scl_fall && st_ff.bitcnt == BITS_PER_BYTE) begin
            nxt_st.sda_oe = 1'b1;
            nxt_st.fsm    = PIC_RX_ACK;
            if (st_ff.bytecnt != BYTES_PER_WR) begin
              nxt_st.bytecnt = st_ff.bytecnt + 3'h1;
            end
            case (st_ff.bytecnt)
              3'h0: nxt_st.ptr[15:8] = st_ff.shreg;
              3'h1: nxt_st.ptr[7:0]  = st_ff.shreg;
              3'h2: nxt_st.wdat_hi   = st_ff.shreg;
              3'h3: begin
                // word commits on its second byte
                case (st_ff.ptr)
                  REG_REF_DIV_FB_HIGH:       nxt_st.reg1 = {st_ff.wdat_hi, st_ff.shreg};
                  REG_FEEDBACK_DIVIDERS:     nxt_st.reg2 = {st_ff.wdat_hi, st_ff.shreg};
                  REG_STATUS_RESET_PRESCALE: nxt_st.reg3 = {st_ff.wdat_hi, st_ff.shreg};
                  REG_INPUT_SELECT_CONFIG:   nxt_st.reg4 = {st_ff.wdat_hi, st_ff.shreg};
                  default:                   nxt_st.reg1 = st_ff.reg1;
                endcase
              end
              default: nxt_st.wdat_hi = st_ff.wdat_hi;
            endcase
          end
        end
        PIC_RX_ACK: begin
          if (scl_fall) begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.bitcnt = 4'h0;
            nxt_st.fsm    = PIC_RX;
          end
        end
        PIC_TX: begin
          if (scl_rise) begin
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (st_ff.bitcnt == BITS_PER_BYTE) begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.fsm    = PIC_TX_ACK;
            end else begin
              nxt_st.shreg  = {st_ff.shreg[6:0], 1'b0};
              nxt_st.sda_oe = ~st_ff.shreg[6];
            end
          end
        end
        PIC_TX_ACK: begin
          if (scl_rise) begin
            // master nack ends the read, wait for stop
            if (sda_s) begin
              nxt_st.fsm = PIC_IDLE;
            end else begin
              nxt_st.rw = 1'b1;
            end
          end else if (scl_fall) begin
            // extra bytes alternate high and low halves of the word
            nxt_st.bitcnt = 4'h0;
            nxt_st.tx_sel = ~st_ff.tx_sel;
            nxt_st.shreg  = st_ff.tx_sel ? rd_word[15:8] : st_ff.tx_lo;
            nxt_st.sda_oe = st_ff.tx_sel ? ~rd_word[15] : ~st_ff.tx_lo[7];
            nxt_st.fsm    = PIC_TX;
          end
        end
        default: begin
          nxt_st.fsm    = PIC_IDLE;
          nxt_st.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      // edge history starts low like the synchronisers, so no false start or stop
      st_ff         <= '0;
      st_ff.fsm     <= PIC_IDLE;
      st_ff.reg1    <= RST_REF_DIV_FB_HIGH;
      st_ff.reg2    <= RST_FEEDBACK_DIVIDERS;
      st_ff.reg3    <= RST_STATUS_RESET_PRESCALE;
      st_ff.reg4    <= RST_INPUT_SELECT_CONFIG;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // open drain: only ever pulls low
  assign o_sda_out = 1'b0;
  assign o_sda_oe  = st_ff.sda_oe;

  // ----------------------------------------
  // pll divider fields
  // ----------------------------------------
  // reference divider plus one
  assign o_reference_divider = st_ff.reg1[REFDIV_MSB:REFDIV_LSB];
  assign o_reference_ratio   = {1'b0, st_ff.reg1[REFDIV_MSB:REFDIV_LSB]} + 15'h0001;
  assign o_feedback_divider_first = {st_ff.reg1[FB1_HI_MSB:0], st_ff.reg2[15:FB1_LO_LSB]};
  assign o_feedback_first_ratio   = {1'b0, o_feedback_divider_first} + 11'h001;
  assign o_feedback_divider_second = st_ff.reg2[FB1_LO_LSB-1:0];
  assign o_feedback_second_ratio   = {1'b0, st_ff.reg2[FB1_LO_LSB-1:0]} + 9'h001;

  // ----------------------------------------
  // status pin routing
  // ----------------------------------------
  // status 1 indication enables
  assign o_status1 = (st_ff.reg3[ST1_REFCLK] & refclk_s) |
                     (st_ff.reg3[ST1_LOSS]   & loss_s)   |
                     (st_ff.reg3[ST1_LOCK]   & lock_s);
  assign o_status0 = (st_ff.reg3[ST0_REFCLK] & refclk_s) |
                     (st_ff.reg3[ST0_LOSS]   & loss_s)   |
                     (st_ff.reg3[ST0_LOCK]   & lock_s);

  // ----------------------------------------
  // reset, sync, calibration, prescalers
  // ----------------------------------------
  // soft reset never touches registers
  assign o_core_reset_n   = st_ff.reg3[SOFT_RST_BIT];
  // sync forced while bit is low
  assign o_divider_sync   = ~st_ff.reg3[SYNC_BIT];
  assign o_vco_cal_enable = st_ff.reg3[CAL_BIT];

  pic_prescale u_ps_second (
    .i_code     (st_ff.reg3[PS2_LSB+1:PS2_LSB]),
    .o_ratio    (o_prescaler_second_ratio),
    .o_reserved (o_prescaler_second_reserved)
  );

  pic_prescale u_ps_first (
    .i_code     (st_ff.reg3[PS1_LSB+1:PS1_LSB]),
    .o_ratio    (o_prescaler_first_ratio),
    .o_reserved (o_prescaler_first_reserved)
  );

  // ----------------------------------------
  // input section
  // ----------------------------------------
  // delay and reshape bits
  assign o_mux_delay_enable   = st_ff.reg4[SHAPE_LSB];
  assign o_mux_reshape_enable = st_ff.reg4[SHAPE_LSB+1];
  assign o_input_mux_manual   = st_ff.reg4[MODE_BIT];
  assign o_ref_use_secondary  = st_ff.reg4[MODE_BIT] & st_ff.reg4[CHOICE_BIT] & refsel_s;
  assign o_primary_input_ratio = {1'b0, st_ff.reg4[PRIDIV_LSB+3:PRIDIV_LSB]} + 5'h01;
  assign o_secondary_buffer_type = st_ff.reg4[SECBUF_LSB+1:SECBUF_LSB];
  // primary has no crystal, 11 folds to cmos
  assign o_primary_buffer_type =
    (st_ff.reg4[PRIBUF_LSB+1]) ? PIC_BUF_CMOS : st_ff.reg4[PRIBUF_LSB+1:PRIBUF_LSB];
  // buffer enables, host keeps both on in auto
  assign o_secondary_input_enable = st_ff.reg4[SEC_EN_BIT];
  assign o_primary_input_enable   = st_ff.reg4[PRI_EN_BIT];
  assign o_secondary_supply_select = st_ff.reg4[SEC_SUP_BIT];
  assign o_primary_supply_select   = st_ff.reg4[PRI_SUP_BIT];

endmodule // pic_regs

// ---- logic/pic_sync.sv ----
`timescale 1ns/10ps
module pic_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  // levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule // pic_sync
